// ### src/tef_pkg.sv
// package of the timer event-flag block: register map, field layout, modes
// assumes: AXI4-Lite slave, 32-bit data, one word per register
package tef_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MOD = 8'h04;
   localparam logic [7:0] OFS_CNT = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_EN = 8'h10;
   localparam logic [7:0] OFS_FLAG_CLR = 8'h14;
   localparam logic [7:0] OFS_CH_BASE = 8'h20;
   localparam logic [7:0] OFS_CH_STRIDE = 8'h08;
   localparam logic [7:0] OFS_CH_VAL = 8'h04;
   // ----------------------------------------------------------------
   // fields
   // ----------------------------------------------------------------
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_UPDOWN_BIT = 1;
   localparam int FLAG_WRAP_BIT = 0;
   localparam int FLAG_CH_LSB = 1;
   localparam int CHC_ELS_LO_BIT = 0;
   localparam int CHC_ELS_HI_BIT = 1;
   localparam int CHC_MODE_LSB = 2;
   localparam int CHC_W = 4;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // channel modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TEF_CH_CAPTURE = 2'h0,
      TEF_CH_COMPARE = 2'h1,
      TEF_CH_EDGE_PWM = 2'h2
   } tef_ch_mode_type;
endpackage : tef_pkg

// ### src/tef_flag_if.sv
// flag request bundle between the top and the flag store
// assumes: single clock domain
`timescale 1ns/100ps
interface tef_flag_if #(parameter int N = 3);
   logic [N-1:0] set;
   logic [N-1:0] rd_seen;
   logic [N-1:0] wr_zero;
   logic [N-1:0] flags;
   modport store (input set, input rd_seen, input wr_zero, output flags);
   modport user (output set, output rd_seen, output wr_zero, input flags);
endinterface : tef_flag_if

// ### src/tef_flag_store.sv
// sticky event flags with read-then-write-zero clearing
// assumes: requests are one-cycle pulses from the top module
`timescale 1ns/100ps
module tef_flag_store #(
   parameter int N = 3
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   tef_flag_if.store fif
);
   logic [N-1:0] flag_reg;
   logic [N-1:0] armed_reg;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_flag
         always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               flag_reg[g] <= 1'b0;
               armed_reg[g] <= 1'b0;
            end else if (fif.set[g]) begin
               flag_reg[g] <= 1'b1;
               armed_reg[g] <= 1'b0;
            end else if (fif.wr_zero[g]) begin
               if (armed_reg[g]) begin
                  flag_reg[g] <= 1'b0;
               end
               armed_reg[g] <= 1'b0;
            end else if (fif.rd_seen[g] && flag_reg[g]) begin
               armed_reg[g] <= 1'b1;
            end
         end
      end
   endgenerate

   assign fif.flags = flag_reg;
endmodule : tef_flag_store

// ### src/tef_top.sv
// timer event-flag logic: 16-bit counter, channels, flags, AXI4-Lite slave
// assumes: channel pins synchronous to CLK_SYS_I; count enable from a divider
`timescale 1ns/100ps
module tef_top #(
   parameter int NCH = 2,
   parameter int PRESCALE = 1
) (
   input wire logic CLK_SYS_I,
   input wire logic ARST_N_I,
   input wire logic [NCH-1:0] CH_PIN_I,
   output logic IRQ_O,
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I
);
   localparam int NF = NCH + 1;

   if (NCH < 1 || NCH > 8 || PRESCALE < 1 || PRESCALE > 65536) begin : g_param_check
      $error("tef_top: unsupported parameter value");
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic run_reg, updown_reg, down_reg;
   logic [15:0] mod_reg;
   logic [15:0] cnt_reg;
   logic [NF-1:0] irq_en_reg;
   logic [tef_pkg::CHC_W-1:0] chc_reg [NCH];
   logic [15:0] chv_reg [NCH];
   logic [NCH-1:0] pin_reg;
   logic [16:0] div_reg;
   logic tick;

   tef_flag_if #(.N(NF)) fif ();

   tef_flag_store #(.N(NF)) i_tef_flag_store (
      .clk_i(CLK_SYS_I),
      .arst_n_i(ARST_N_I),
      .fif(fif)
   );

   // ----------------------------------------------------------------
   // count enable divider
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         div_reg <= 17'h00000;
      end else if (!run_reg || div_reg == 17'(PRESCALE - 1)) begin
         div_reg <= 17'h00000;
      end else begin
         div_reg <= div_reg + 17'h00001;
      end
   end
   assign tick = run_reg && (div_reg == 17'(PRESCALE - 1));

   // ----------------------------------------------------------------
   // main counter
   // ----------------------------------------------------------------
   logic [15:0] top_val;
   logic at_top, wrap_evt;
   assign top_val = (mod_reg == tef_pkg::CNT_ZERO) ? tef_pkg::CNT_MAX : mod_reg;
   assign at_top = (cnt_reg == top_val);
   // up/down turns only at a nonzero modulus
   assign wrap_evt = tick && (updown_reg ? (!down_reg && cnt_reg == mod_reg && mod_reg != tef_pkg::CNT_ZERO)
                                          : at_top);

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cnt_reg <= tef_pkg::CNT_ZERO;
         down_reg <= 1'b0;
      end else if (tick) begin
         if (!updown_reg) begin
            down_reg <= 1'b0;
            cnt_reg <= at_top ? tef_pkg::CNT_ZERO : cnt_reg + 16'h0001;
         end else if (!down_reg) begin
            if (cnt_reg == mod_reg && mod_reg != tef_pkg::CNT_ZERO) begin
               down_reg <= 1'b1;
               cnt_reg <= cnt_reg - 16'h0001;
            end else begin
               cnt_reg <= cnt_reg + 16'h0001;
            end
         end else if (cnt_reg == tef_pkg::CNT_ZERO) begin
            down_reg <= 1'b0;
            cnt_reg <= cnt_reg + 16'h0001;
         end else begin
            cnt_reg <= cnt_reg - 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // channel events
   // ----------------------------------------------------------------
   logic [NCH-1:0] ch_evt;
   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         logic rise, fall, sel_lo, sel_hi, match;
         tef_pkg::tef_ch_mode_type mode;
         assign sel_lo = chc_reg[c][tef_pkg::CHC_ELS_LO_BIT];
         assign sel_hi = chc_reg[c][tef_pkg::CHC_ELS_HI_BIT];
         assign mode = tef_pkg::tef_ch_mode_type'(chc_reg[c][tef_pkg::CHC_MODE_LSB +: 2]);
         assign rise = CH_PIN_I[c] && !pin_reg[c];
         assign fall = !CH_PIN_I[c] && pin_reg[c];
         // match is sampled once per count step
         assign match = tick && (cnt_reg == chv_reg[c]);
         always_comb begin
            if (updown_reg) begin
               ch_evt[c] = match;
            end else begin
               case (mode)
                  tef_pkg::TEF_CH_CAPTURE: ch_evt[c] = (sel_lo && rise) || (sel_hi && fall);
                  tef_pkg::TEF_CH_COMPARE: ch_evt[c] = match;
                  tef_pkg::TEF_CH_EDGE_PWM: ch_evt[c] = match;
                  default: ch_evt[c] = 1'b0;
               endcase
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pin_reg <= '0;
      end else begin
         pin_reg <= CH_PIN_I;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   logic aw_full_reg, w_full_reg, bvalid_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [1:0] bresp_reg;
   logic wr_go, wr_ok;
   logic [NF-1:0] wr_zero;

   assign S_AXI_AWREADY_O = !aw_full_reg && !bvalid_reg;
   assign S_AXI_WREADY_O = !w_full_reg && !bvalid_reg;
   assign S_AXI_BVALID_O = bvalid_reg;
   assign S_AXI_BRESP_O = bresp_reg;
   assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;

   function automatic logic addr_ok(input logic [7:0] a);
      logic ok;
      ok = (a == tef_pkg::OFS_CTRL) || (a == tef_pkg::OFS_MOD) || (a == tef_pkg::OFS_CNT) ||
           (a == tef_pkg::OFS_FLAGS) || (a == tef_pkg::OFS_IRQ_EN) || (a == tef_pkg::OFS_FLAG_CLR);
      for (int i = 0; i < NCH; i++) begin
         if (a == 8'(tef_pkg::OFS_CH_BASE + i * tef_pkg::OFS_CH_STRIDE) ||
             a == 8'(tef_pkg::OFS_CH_BASE + i * tef_pkg::OFS_CH_STRIDE + tef_pkg::OFS_CH_VAL)) begin
            ok = 1'b1;
         end
      end
      return ok;
   endfunction : addr_ok

   assign wr_ok = addr_ok(aw_addr_reg);

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= tef_pkg::AXI_OKAY;
      end else begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= {S_AXI_AWADDR_I[7:2], 2'h0};
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_full_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA_I;
            w_strb_reg <= S_AXI_WSTRB_I;
         end
         if (wr_go) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? tef_pkg::AXI_OKAY : tef_pkg::AXI_SLVERR;
         end else if (bvalid_reg && S_AXI_BREADY_I) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // register stores
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         run_reg <= 1'b0;
         updown_reg <= 1'b0;
         mod_reg <= tef_pkg::CNT_ZERO;
         irq_en_reg <= '0;
      end else if (wr_go) begin
         if (aw_addr_reg == tef_pkg::OFS_CTRL && w_strb_reg[0]) begin
            run_reg <= w_data_reg[tef_pkg::CTRL_RUN_BIT];
            updown_reg <= w_data_reg[tef_pkg::CTRL_UPDOWN_BIT];
         end
         if (aw_addr_reg == tef_pkg::OFS_MOD) begin
            if (w_strb_reg[0]) mod_reg[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1]) mod_reg[15:8] <= w_data_reg[15:8];
         end
         if (aw_addr_reg == tef_pkg::OFS_IRQ_EN && w_strb_reg[0]) begin
            irq_en_reg <= w_data_reg[NF-1:0];
         end
      end
   end

   generate
      for (c = 0; c < NCH; c++) begin : g_chreg
         localparam logic [7:0] CA = 8'(tef_pkg::OFS_CH_BASE + c * tef_pkg::OFS_CH_STRIDE);
         always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
               chc_reg[c] <= '0;
               chv_reg[c] <= tef_pkg::CNT_ZERO;
            end else if (wr_go) begin
               if (aw_addr_reg == CA && w_strb_reg[0]) begin
                  chc_reg[c] <= w_data_reg[tef_pkg::CHC_W-1:0];
               end
               if (aw_addr_reg == 8'(CA + tef_pkg::OFS_CH_VAL)) begin
                  if (w_strb_reg[0]) chv_reg[c][7:0] <= w_data_reg[7:0];
                  if (w_strb_reg[1]) chv_reg[c][15:8] <= w_data_reg[15:8];
               end
            end
         end
      end
   endgenerate

   // zero-write to a flag position of the flag register, or one-write to it in the clear register
   always_comb begin
      wr_zero = '0;
      if (wr_go && w_strb_reg[0] && aw_addr_reg == tef_pkg::OFS_FLAGS) begin
         wr_zero = ~w_data_reg[NF-1:0];
      end else if (wr_go && w_strb_reg[0] && aw_addr_reg == tef_pkg::OFS_FLAG_CLR) begin
         wr_zero = w_data_reg[NF-1:0];
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   logic rvalid_reg, rd_ok, rd_take;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rd_mux;
   logic [7:0] ar_addr;

   assign ar_addr = {S_AXI_ARADDR_I[7:2], 2'h0};
   assign S_AXI_ARREADY_O = !rvalid_reg;
   assign rd_take = S_AXI_ARVALID_I && !rvalid_reg;
   assign rd_ok = addr_ok(ar_addr) && ar_addr != tef_pkg::OFS_FLAG_CLR;
   assign S_AXI_RVALID_O = rvalid_reg;
   assign S_AXI_RDATA_O = rdata_reg;
   assign S_AXI_RRESP_O = rresp_reg;

   always_comb begin
      rd_mux = 32'h00000000;
      case (ar_addr)
         tef_pkg::OFS_CTRL: rd_mux = {30'h00000000, updown_reg, run_reg};
         tef_pkg::OFS_MOD: rd_mux = {16'h0000, mod_reg};
         tef_pkg::OFS_CNT: rd_mux = {16'h0000, cnt_reg};
         tef_pkg::OFS_FLAGS: rd_mux = 32'(fif.flags);
         tef_pkg::OFS_IRQ_EN: rd_mux = 32'(irq_en_reg);
         default: begin
            for (int i = 0; i < NCH; i++) begin
               if (ar_addr == 8'(tef_pkg::OFS_CH_BASE + i * tef_pkg::OFS_CH_STRIDE)) begin
                  rd_mux = 32'(chc_reg[i]);
               end
               if (ar_addr == 8'(tef_pkg::OFS_CH_BASE + i * tef_pkg::OFS_CH_STRIDE + tef_pkg::OFS_CH_VAL)) begin
                  rd_mux = {16'h0000, chv_reg[i]};
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= tef_pkg::AXI_OKAY;
      end else if (rd_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_ok ? rd_mux : 32'h00000000;
         rresp_reg <= rd_ok ? tef_pkg::AXI_OKAY : tef_pkg::AXI_SLVERR;
      end else if (rvalid_reg && S_AXI_RREADY_I) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // flag requests and interrupt
   // ----------------------------------------------------------------
   assign fif.set = {ch_evt, wrap_evt};
   assign fif.rd_seen = (rd_take && ar_addr == tef_pkg::OFS_FLAGS) ? fif.flags : '0;
   assign fif.wr_zero = wr_zero;
   assign IRQ_O = |(fif.flags & irq_en_reg);
endmodule : tef_top

// ### dv/tef_top_properties.sv
// checker of the timer event-flag top: bus handshakes and interrupt relations
// assumes: bound to tef_top, one clock domain, async active-low reset
`timescale 1ns/100ps
module tef_top_properties (
   input wire logic CLK_SYS_I,
   input wire logic ARST_N_I,
   input wire logic IRQ_O,
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic [1:0] S_AXI_RRESP_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!ARST_N_I);
   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   sequence s_wr_taken;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
   endsequence
   sequence s_b_soon;
      ##[1:3] S_AXI_BVALID_O;
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   chk_write_answer: assert property (s_wr_taken |-> s_b_soon)
      else $error("write response missing");
   chk_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("read response late");
   chk_b_single: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
      else $error("write response repeated");
   chk_r_single: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
      else $error("read response repeated");
   chk_wr_blocked: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
      else $error("write accepted while response pending");
   chk_rd_blocked: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
      else $error("read accepted while response pending");
   chk_clr_unreadable: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O &&
      S_AXI_ARADDR_I == tef_pkg::OFS_FLAG_CLR |=> S_AXI_RRESP_O == tef_pkg::AXI_SLVERR)
      else $error("clear register readable");
   chk_err_data_zero: assert property (S_AXI_RVALID_O && S_AXI_RRESP_O == tef_pkg::AXI_SLVERR |->
      S_AXI_RDATA_O == 32'h00000000) else $error("error read returned data");
   chk_irq_fall_write: assert property ($fell(IRQ_O) |-> S_AXI_BVALID_O)
      else $error("interrupt dropped without a register write");
endmodule : tef_top_properties
bind tef_top tef_top_properties i_tef_top_properties (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I),
   .IRQ_O(IRQ_O), .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
   .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
   .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
   .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
   .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I));

// ### dv/tef_top_bench.sv
// self-checking bench of the timer event-flag top over AXI4-Lite
// assumes: two channels, one clock per count tick, checker bound separately
`timescale 1ns/100ps
module tef_top_bench;
   localparam logic [7:0] A_CTRL = tef_pkg::OFS_CTRL;
   localparam logic [7:0] A_MOD = tef_pkg::OFS_MOD;
   localparam logic [7:0] A_CNT = tef_pkg::OFS_CNT;
   localparam logic [7:0] A_FLG = tef_pkg::OFS_FLAGS;
   localparam logic [7:0] A_EN = tef_pkg::OFS_IRQ_EN;
   localparam logic [7:0] A_C0 = tef_pkg::OFS_CH_BASE;
   localparam logic [7:0] A_V0 = tef_pkg::OFS_CH_BASE + tef_pkg::OFS_CH_VAL;
   localparam logic [7:0] A_C1 = tef_pkg::OFS_CH_BASE + tef_pkg::OFS_CH_STRIDE;
   logic clk = 1'b0, arst_n = 1'b0, irq, awready, wready, bvalid, arready, rvalid;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [1:0] pin = 2'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000, rdata, d, c1, c2;
   logic [1:0] bresp, rresp, r, dir;
   logic [3:0] md [4] = '{4'h4, 4'h4, 4'h8, 4'h8};
   logic [31:0] vl [4] = '{32'h00000005, 32'h00000020, 32'h00000005, 32'h00000020};
   int errors = 0, num_checks = 0, n;
   always #12.5 clk = ~clk;
   tef_top #(.NCH(2), .PRESCALE(1)) i_tef_top (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .CH_PIN_I(pin), .IRQ_O(irq),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task test_done;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   task tmo;
      errors++;
      $display("MISMATCH %0t wait ran out", $time);
      test_done();
   endtask : tmo
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int k;
      logic done;
      done = 1'b0;
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (k = 0; k < 64 && !done; k++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            done = 1'b1; r = bresp; bready <= 1'b0;
         end
      end
      // idle edge so the next call does not re-drive bready in this step
      @(posedge clk);
      if (!done) tmo();
   endtask : wr
   task automatic rd(input logic [7:0] a);
      int k;
      logic done;
      done = 1'b0;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (k = 0; k < 64 && !done; k++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            done = 1'b1; d = rdata; r = rresp; rready <= 1'b0;
         end
      end
      // idle edge so the next call does not re-drive rready in this step
      @(posedge clk);
      if (!done) tmo();
   endtask : rd
   task automatic wait_irq(input int bound);
      for (n = 0; n < bound && irq !== 1'b1; n++) @(posedge clk);
      if (n >= bound) tmo();
   endtask : wait_irq
   task clr;
      rd(A_FLG);
      wr(A_FLG, 32'h00000000);
   endtask : clr
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd(A_CTRL); chk(d, 32'h00000000, "ctrl reset");
      rd(A_FLG); chk(d, 32'h00000000, "flags reset");
      rd(A_EN); chk(d, 32'h00000000, "enable reset");
      wr(A_CNT, 32'h00000005); rd(A_CNT); chk(d, 32'h00000000, "counter not writable");
      rd(8'hFC); chk({30'h0, r}, {30'h0, tef_pkg::AXI_SLVERR}, "unmapped read response");
      wr(8'hFC, 32'h00000001); chk({30'h0, r}, {30'h0, tef_pkg::AXI_SLVERR}, "unmapped write response");
      rd(tef_pkg::OFS_FLAG_CLR); chk({30'h0, r}, {30'h0, tef_pkg::AXI_SLVERR}, "clear register read");
      // modulus wrap, then clear sequence
      wr(A_MOD, 32'h00000010); wr(A_EN, 32'h00000001); wr(A_CTRL, 32'h00000001);
      wait_irq(64);
      repeat (4) begin
         rd(A_CNT); chk({31'h0, d <= 32'h00000010}, 32'h00000001, "count within modulus");
      end
      wr(A_CTRL, 32'h00000000);
      wr(A_FLG, 32'h00000000); rd(A_FLG); chk(d, 32'h00000001, "unarmed zero-write");
      wr(A_FLG, 32'h00000001); rd(A_FLG); chk(d, 32'h00000001, "write of one");
      chk({31'h0, irq}, 32'h00000001, "interrupt held");
      wr(A_FLG, 32'h00000000); rd(A_FLG); chk(d, 32'h00000000, "armed clear");
      chk({31'h0, irq}, 32'h00000000, "interrupt released");
      // edge selection on channel 1, every setting
      for (logic [2:0] s = 3'h0; s < 3'h4; s++) begin
         wr(A_C1, {29'h0, s});
         pin[1] <= 1'b1; repeat (4) @(posedge clk);
         rd(A_FLG); chk({31'h0, d[2]}, {31'h0, s[0]}, "rising edge flag");
         wr(A_FLG, 32'h00000000);
         pin[1] <= 1'b0; repeat (4) @(posedge clk);
         rd(A_FLG); chk({31'h0, d[2]}, {31'h0, s[1]}, "falling edge flag");
         wr(A_FLG, 32'h00000000);
      end
      // new event between read and zero-write
      wr(A_C0, 32'h00000001); wr(A_EN, 32'h00000002);
      pin[0] <= 1'b1; repeat (4) @(posedge clk);
      chk({31'h0, irq}, 32'h00000001, "channel interrupt");
      rd(A_FLG); chk(d, 32'h00000002, "capture flag");
      pin[0] <= 1'b0; repeat (2) @(posedge clk);
      pin[0] <= 1'b1; repeat (4) @(posedge clk);
      wr(A_FLG, 32'h00000000); rd(A_FLG); chk(d, 32'h00000002, "restarted clear");
      wr(A_EN, 32'h00000000); chk({31'h0, irq}, 32'h00000000, "masked interrupt");
      wr(A_EN, 32'h00000002); wr(tef_pkg::OFS_FLAG_CLR, 32'h00000002);
      chk({31'h0, irq}, 32'h00000000, "cleared channel");
      // compare and edge PWM, matching and unreachable values
      for (int i = 0; i < 4; i++) begin
         wr(A_C0, {28'h0, md[i]}); wr(A_V0, vl[i]); clr();
         wr(A_CTRL, 32'h00000001); repeat (40) @(posedge clk); wr(A_CTRL, 32'h00000000);
         rd(A_FLG); chk({31'h0, d[1]}, {31'h0, i % 2 == 0}, "match flag");
      end
      // up/down: wrap at the turn, then alternating matches
      wr(A_MOD, 32'h00000020); wr(A_EN, 32'h00000001); clr(); wr(A_CTRL, 32'h00000003);
      wait_irq(128);
      rd(A_CNT); c1 = d; rd(A_CNT); c2 = d;
      chk({31'h0, c2 < c1 && c1 <= 32'h00000020}, 32'h00000001, "down after turn");
      wr(A_V0, 32'h00000010); wr(A_EN, 32'h00000002); clr();
      for (int k = 0; k < 2; k++) begin
         wait_irq(128);
         rd(A_CNT); c1 = d; rd(A_CNT); c2 = d;
         dir[k] = c2 > c1;
         if (k == 0) clr();
      end
      chk({31'h0, dir[0] ^ dir[1]}, 32'h00000001, "centred matches both ways");
      // free run to the maximum count
      wr(A_CTRL, 32'h00000000); wr(A_MOD, 32'h00000000); wr(A_EN, 32'h00000001); clr();
      wr(A_CTRL, 32'h00000001);
      wait_irq(66000);
      chk({31'h0, n > 65000}, 32'h00000001, "wrap only at maximum");
      rd(A_CNT); chk({31'h0, d < 32'h00000010}, 32'h00000001, "count wrapped to zero");
      test_done();
   end
endmodule : tef_top_bench
